// ==== hdl/see_map.svh ====
`ifndef SEE_MAP_SVH
`define SEE_MAP_SVH
// ****************************************************************
// timing
// ****************************************************************
`define SEE_CLK_PERIOD_NS   5
`define SEE_PROG_TIME_NS    5000000
// ****************************************************************
// address byte layout and array geometry
// ****************************************************************
`define SEE_DEV_TYPE        4'ha
`define SEE_TYPE_MSB        7
`define SEE_TYPE_LSB        4
`define SEE_SEL_MSB         3
`define SEE_SEL_LSB         1
`define SEE_RW_BIT          0
`define SEE_ACK_SLOT        4'h8
`define SEE_ACK_END         4'h9
`define SEE_WORDS           256
`define SEE_PAGE_BYTES      8
`define SEE_FIFO_DEPTH      4
`endif

// ==== hdl/see_pkg.sv ====
package see_pkg;
  // bus phase of the slave
  typedef enum logic [2:0] {
    ST_IDLE, ST_DEVADDR, ST_WORDADDR, ST_WDATA, ST_RDATA, ST_PROG
  } see_state_t;
endpackage

// ==== hdl/see_top.sv ====
`timescale 1ns/10ps
`include "see_map.svh"

// ****************************************************************
// small fifo with flush
// ****************************************************************
module see_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `SEE_FIFO_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  // handshakes
  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_reg[rd_ptr_reg];

  // storage, no reset needed on data
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk) begin
    if (!rst_n || flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // see_fifo

// ****************************************************************
// two-wire memory slave
// ****************************************************************
module see_top
  import see_pkg::*;
#(
  parameter int PROG_CYCLES = `SEE_PROG_TIME_NS / `SEE_CLK_PERIOD_NS
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  input  wire logic       write_protect,
  input  wire logic [2:0] chip_select_straps,
  output logic            prog_busy
);
  localparam int PW = $clog2(PROG_CYCLES + 1);

  logic [1:0]  scl_sync_reg;
  logic [1:0]  sda_sync_reg;
  logic [1:0]  wp_sync_reg;
  logic [2:0]  sel_sync0_reg;
  logic [2:0]  sel_sync1_reg;
  logic        scl_d_reg;
  logic        sda_d_reg;
  see_state_t  state_reg;
  logic [3:0]  bit_cnt_reg;
  logic [7:0]  shift_reg;
  logic [7:0]  tx_reg;
  logic        rw_reg;
  logic        mack_reg;
  logic [7:0]  addr_cnt_reg;
  logic [7:0]  fetch_ptr_reg;
  logic [7:0]  stage_reg [`SEE_PAGE_BYTES];
  logic [7:0]  stage_vld_reg;
  logic [4:0]  page_reg;
  logic [PW-1:0] prog_cnt_reg;
  logic        oe_reg;
  logic        flush_reg;
  logic [7:0]  mem [`SEE_WORDS];
  logic        scl_s;
  logic        sda_s;
  logic        wp_s;
  logic        rise;
  logic        fall;
  logic        start_det;
  logic        stop_det;
  logic        byte_done;
  logic        ack_end;
  logic        dev_match;
  logic        commit;
  logic        go_prog;
  logic        load_tx;
  logic        flush_req;
  logic        fetch_valid;
  logic        fetch_ready;
  logic        rd_valid;
  logic [7:0]  rd_data;

  // pins pass two flops before use
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scl_sync_reg  <= 2'h3;
      sda_sync_reg  <= 2'h3;
      wp_sync_reg   <= 2'h0;
      sel_sync0_reg <= 3'h0;
      sel_sync1_reg <= 3'h0;
      scl_d_reg     <= 1'b1;
      sda_d_reg     <= 1'b1;
    end else begin
      scl_sync_reg  <= {scl_sync_reg[0], scl_i};
      sda_sync_reg  <= {sda_sync_reg[0], sda_i};
      wp_sync_reg   <= {wp_sync_reg[0], write_protect};
      sel_sync0_reg <= chip_select_straps;
      sel_sync1_reg <= sel_sync0_reg;
      scl_d_reg     <= scl_sync_reg[1];
      sda_d_reg     <= sda_sync_reg[1];
    end
  end
  // bus events seen from the synchronised lines
  assign scl_s     = scl_sync_reg[1];
  assign sda_s     = sda_sync_reg[1];
  assign wp_s      = wp_sync_reg[1];
  assign rise      = scl_s && !scl_d_reg;
  assign fall      = !scl_s && scl_d_reg;
  // programming makes the slave deaf, starts included
  assign start_det = scl_s && scl_d_reg && sda_d_reg && !sda_s && (state_reg != ST_PROG);
  assign stop_det  = scl_s && scl_d_reg && !sda_d_reg && sda_s && (state_reg != ST_PROG);
  assign byte_done = fall && (bit_cnt_reg == `SEE_ACK_SLOT);
  assign ack_end   = fall && (bit_cnt_reg == `SEE_ACK_END);
  assign dev_match = (shift_reg[`SEE_TYPE_MSB:`SEE_TYPE_LSB] == `SEE_DEV_TYPE) &&
                     (shift_reg[`SEE_SEL_MSB:`SEE_SEL_LSB] == sel_sync1_reg);
  // protected writes are acked but never reach the array
  assign go_prog   = stop_det && (state_reg == ST_WDATA) && (stage_vld_reg != 8'h0) && !wp_s;
  assign commit    = (state_reg == ST_PROG) && (prog_cnt_reg == '0);
  assign load_tx   = ack_end && (((state_reg == ST_DEVADDR) && rw_reg) ||
                                 ((state_reg == ST_RDATA) && mack_reg));
  assign flush_req = start_det || (byte_done && (state_reg == ST_WORDADDR)) || commit;
  assign prog_busy = (state_reg == ST_PROG);
  // bus phase sequencing
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
    end else if (state_reg == ST_PROG) begin
      if (commit) begin
        state_reg <= ST_IDLE;
      end
    end else if (start_det) begin
      state_reg <= ST_DEVADDR;
    end else if (stop_det) begin
      state_reg <= go_prog ? ST_PROG : ST_IDLE;
    end else if (byte_done && (state_reg == ST_DEVADDR) && !dev_match) begin
      state_reg <= ST_IDLE;
    end else if (ack_end) begin
      case (state_reg)
        ST_DEVADDR:  state_reg <= rw_reg ? ST_RDATA : ST_WORDADDR;
        ST_WORDADDR: state_reg <= ST_WDATA;
        ST_RDATA:    state_reg <= mack_reg ? ST_RDATA : ST_IDLE;
        default:     state_reg <= state_reg;
      endcase
    end
  end
  // bit position: 0..7 data, 8..9 acknowledge clock
  always_ff @(posedge clk) begin
    if (!rst_n || start_det || ack_end) begin
      bit_cnt_reg <= 4'h0;
    end else if (rise && (bit_cnt_reg != `SEE_ACK_END)) begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end
  end
  // receive shifter, msb first on rising scl
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shift_reg <= 8'h0;
    end else if (rise && (bit_cnt_reg < `SEE_ACK_SLOT)) begin
      shift_reg <= {shift_reg[6:0], sda_s};
    end
  end
  // direction bit and master acknowledge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rw_reg   <= 1'b0;
      mack_reg <= 1'b0;
    end else begin
      if (byte_done && (state_reg == ST_DEVADDR)) begin
        rw_reg <= shift_reg[`SEE_RW_BIT];
      end
      if (rise && (bit_cnt_reg == `SEE_ACK_SLOT) && (state_reg == ST_RDATA)) begin
        mack_reg <= !sda_s;
      end
    end
  end
  // address counter survives between operations
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      addr_cnt_reg <= 8'h0;
    end else if (byte_done && (state_reg == ST_WORDADDR)) begin
      addr_cnt_reg <= shift_reg;
    end else if (byte_done && (state_reg == ST_WDATA)) begin
      addr_cnt_reg <= {addr_cnt_reg[7:3], addr_cnt_reg[2:0] + 3'h1};
    end else if (rise && (bit_cnt_reg == `SEE_ACK_SLOT) && (state_reg == ST_RDATA)) begin
      addr_cnt_reg <= addr_cnt_reg + 8'h1;
    end
  end
  // page staging; a ninth byte overwrites the first
  always_ff @(posedge clk) begin
    if (!rst_n || start_det || commit) begin
      stage_vld_reg <= 8'h0;
    end else if (stop_det && !go_prog) begin
      stage_vld_reg <= 8'h0;
    end else if (byte_done && (state_reg == ST_WDATA)) begin
      stage_reg[addr_cnt_reg[2:0]]     <= shift_reg;
      stage_vld_reg[addr_cnt_reg[2:0]] <= 1'b1;
      page_reg                         <= addr_cnt_reg[7:3];
    end
  end
  // self-timed programming delay
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prog_cnt_reg <= '0;
    end else if (go_prog) begin
      prog_cnt_reg <= PW'(PROG_CYCLES - 1);
    end else if ((state_reg == ST_PROG) && (prog_cnt_reg != '0)) begin
      prog_cnt_reg <= prog_cnt_reg - 1'b1;
    end
  end

  // array update at end of the cycle; contents are not reset
  always_ff @(posedge clk) begin
    if (commit) begin
      for (int i = 0; i < `SEE_PAGE_BYTES; i++) begin
        if (stage_vld_reg[i]) begin
          mem[{page_reg, 3'(i)}] <= stage_reg[i];
        end
      end
    end
  end

  // prefetch pointer follows the counter after each flush
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flush_reg     <= 1'b0;
      fetch_ptr_reg <= 8'h0;
    end else begin
      flush_reg <= flush_req;
      if (flush_reg) begin
        fetch_ptr_reg <= addr_cnt_reg;
      end else if (fetch_valid && fetch_ready) begin
        fetch_ptr_reg <= fetch_ptr_reg + 8'h1;
      end
    end
  end

  // the serial side drains the fifo, so it stalls the fetcher
  assign fetch_valid = (state_reg != ST_PROG) && !flush_req && !flush_reg;

  see_fifo #(
    .WIDTH (8),
    .DEPTH (`SEE_FIFO_DEPTH)
  ) u_rd_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .flush     (flush_reg),
    .in_valid  (fetch_valid),
    .in_ready  (fetch_ready),
    .in_data   (mem[fetch_ptr_reg]),
    .out_valid (rd_valid),
    .out_ready (load_tx),
    .out_data  (rd_data)
  );

  // transmit shifter and open-drain drive
  always_ff @(posedge clk) begin
    if (!rst_n || start_det || stop_det || (state_reg == ST_PROG)) begin
      oe_reg <= 1'b0;
      tx_reg <= 8'h0;
    end else if (byte_done) begin
      oe_reg <= ((state_reg == ST_DEVADDR) && dev_match) ||
                (state_reg == ST_WORDADDR) || (state_reg == ST_WDATA);
    end else if (load_tx) begin
      tx_reg <= rd_data;
      oe_reg <= !rd_data[7];
    end else if (ack_end) begin
      oe_reg <= 1'b0;
    end else if (fall && (state_reg == ST_RDATA) && (bit_cnt_reg != 4'h0)) begin
      tx_reg <= {tx_reg[6:0], 1'b0};
      oe_reg <= !tx_reg[6];
    end
  end

  // only ever pulls low
  assign sda_o  = 1'b0;
  assign sda_oe = oe_reg;
endmodule // see_top

// ==== tb/see_master.sv ====
`timescale 1ns/10ps
// ****************
// bus master model
// ****************
module see_master (
  input  wire logic clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      m_oe
);
  int hq_n = 8; // quarter scl period in clk; raise for a slow master
  initial begin
    scl = 1'b1;
    m_oe = 1'b0;
  end
  task automatic hq();
    repeat (hq_n) @(negedge clk);
  endtask
  // sda falls while scl high, bus idle or repeated
  task automatic start();
    m_oe = 1'b0;
    hq();
    scl = 1'b1;
    hq();
    m_oe = 1'b1;
    hq();
    scl = 1'b0;
    hq();
  endtask
  // sda rises while scl high; pull-up takes the line
  task automatic stop();
    m_oe = 1'b1;
    hq();
    scl = 1'b1;
    hq();
    m_oe = 1'b0;
    hq();
  endtask
  // data moves only while scl is low
  task automatic xfer_bit(input logic b, output logic r);
    m_oe = !b;
    hq();
    scl = 1'b1;
    hq();
    r = sda_line;
    hq();
    scl = 1'b0;
    hq();
  endtask
  // msb first, ninth clock carries the acknowledge; ack_in 1 means nack
  task automatic byte_x(input logic [7:0] d, input logic ack_in, output logic [7:0] r,
                        output logic ack);
    for (int i = 7; i >= 0; i--) xfer_bit(d[i], r[i]);
    xfer_bit(ack_in, ack);
  endtask
endmodule // see_master

// ==== tb/see_top_asserts.sv ====
`timescale 1ns/10ps
// ****************
// slave pin checks
// ****************
module see_top_asserts #(
  parameter int PROG_CYCLES = 50
) (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe,
  input wire logic       write_protect,
  input wire logic [2:0] chip_select_straps,
  input wire logic       prog_busy
);
  int busy_cnt_reg;
  // length of the current programming run
  always_ff @(posedge clk) begin
    if (!rst_n) busy_cnt_reg <= 0;
    else if (prog_busy) busy_cnt_reg <= busy_cnt_reg + 1;
    else busy_cnt_reg <= 0;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_low_only; sda_o == 1'b0; endproperty
  a_low_only: assert property (p_low_only) else $error("sda driven high");
  // edges seen through two flops, so allow 2-7 cycles after the pin falls
  property p_oe_edge; $changed(sda_oe) |-> !scl_i && !$past(scl_i, 2) && $past(scl_i, 8); endproperty
  a_oe_edge: assert property (p_oe_edge) else $error("sda moved outside scl low");
  property p_oe_stands; $rose(sda_oe) |=> sda_oe [*8]; endproperty
  a_oe_stands: assert property (p_oe_stands) else $error("driven bit too short");
  property p_busy_deaf; prog_busy |-> !sda_oe; endproperty
  a_busy_deaf: assert property (p_busy_deaf) else $error("answer while programming");
  property p_busy_stop; $rose(prog_busy) |-> scl_i && sda_i && $past(scl_i, 4); endproperty
  a_busy_stop: assert property (p_busy_stop) else $error("programming without stop");
  property p_busy_holds; $rose(prog_busy) |=> prog_busy [*8]; endproperty
  a_busy_holds: assert property (p_busy_holds) else $error("programming cut short");
  property p_busy_len; $fell(prog_busy) |-> busy_cnt_reg == PROG_CYCLES; endproperty
  a_busy_len: assert property (p_busy_len) else $error("programming length off");
  property p_busy_max; busy_cnt_reg <= PROG_CYCLES; endproperty
  a_busy_max: assert property (p_busy_max) else $error("programming overran");
  property p_wp; $rose(prog_busy) |-> !(write_protect && $past(write_protect, 6)); endproperty
  a_wp: assert property (p_wp) else $error("programming while protected");
endmodule // see_top_asserts

bind see_top see_top_asserts #(.PROG_CYCLES(PROG_CYCLES)) see_top_asserts_i (
  .clk(clk), .rst_n(rst_n), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
  .write_protect(write_protect), .chip_select_straps(chip_select_straps), .prog_busy(prog_busy));

// ==== tb/see_top_test.sv ====
`timescale 1ns/10ps
`include "see_map.svh"
module see_top_test
  import see_pkg::*;
;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       write_protect = 1'b0;
  logic [2:0] straps = 3'h0;
  logic       sda_o, sda_oe, prog_busy, scl, m_oe;
  wire        sda_line = ~(sda_oe | m_oe);
  logic [7:0] mem_exp [256];
  logic [7:0] cnt_exp;
  int         fail_count = 0, checked = 0, cyc = 0, seed = 32'h21a6;
  always #2.5 clk = ~clk;
  // short programming time keeps the run small but longer than one poll byte
  see_top #(.PROG_CYCLES(800)) see_top_i (.clk(clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe(sda_oe), .write_protect(write_protect), .chip_select_straps(straps),
    .prog_busy(prog_busy));
  see_master see_master_i (.clk(clk), .sda_line(sda_line), .scl(scl), .m_oe(m_oe));
  // ****************
  // helpers
  // ****************
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("mismatches %0d checks %0d", fail_count, checked);
    if (fail_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  function automatic logic [7:0] dev(logic rw);
    return {`SEE_DEV_TYPE, straps, rw};
  endfunction
  function automatic logic [7:0] page_next(logic [7:0] a);
    return {a[7:3], a[2:0] + 3'h1};
  endfunction
  task automatic send(input logic [7:0] d, input logic exp_ack);
    logic [7:0] r;
    logic       k;
    see_master_i.byte_x(d, 1'b1, r, k);
    chk("ack", {7'h0, exp_ack}, {7'h0, k});
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 2000 && prog_busy !== 1'b0; i++) @(negedge clk);
  endtask
  // page write from a, poll once while busy, wait for prog_busy to drop, then poll once for the ack
  task automatic wr(input logic [7:0] a, input int n);
    logic [7:0] d;
    see_master_i.start();
    send(dev(1'b0), 1'b0);
    send(a, 1'b0);
    repeat (n) begin
      d = 8'($random(seed));
      send(d, 1'b0);
      if (!write_protect) mem_exp[a] = d;
      a = page_next(a);
    end
    see_master_i.stop();
    repeat (6) @(negedge clk);
    chk("busy", {7'h0, !write_protect}, {7'h0, prog_busy});
    see_master_i.start();
    send(dev(1'b0), !write_protect);
    wait_idle();
    see_master_i.start();
    send(dev(1'b0), 1'b0);
    see_master_i.stop();
    wait_idle();
  endtask
  // optional dummy write of the word address, then n bytes read
  task automatic rd(input logic [7:0] a, input int n, input logic set);
    logic [7:0] r;
    logic       k;
    see_master_i.start();
    if (set) begin
      send(dev(1'b0), 1'b0);
      send(a, 1'b0);
      see_master_i.start();
      cnt_exp = a;
    end
    send(dev(1'b1), 1'b0);
    for (int i = 1; i <= n; i++) begin
      see_master_i.byte_x(8'hff, i == n, r, k);
      chk("read", mem_exp[cnt_exp], r);
      cnt_exp++;
    end
    see_master_i.stop();
  endtask
  // ****************
  // main sequence
  // ****************
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      print_verdict();
    end
  end
  initial begin
    straps = 3'($random(seed));
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    see_master_i.start();
    send({4'hb, straps, 1'b0}, 1'b1);
    see_master_i.start();
    send({`SEE_DEV_TYPE, ~straps, 1'b0}, 1'b1);
    see_master_i.stop();
    wr(8'h3e, 8); // full page from 3e wraps to 38
    wr(8'hff, 1);
    wr(8'h00, 1);
    rd(8'h38, 7, 1'b1);
    rd(8'h00, 1, 1'b0); // counter carries on to 3f
    rd(8'hff, 2, 1'b1); // top wraps to zero
    write_protect = 1'b1;
    see_master_i.hq_n = 14;
    wr(8'h38, 2);
    write_protect = 1'b0;
    see_master_i.hq_n = 8;
    rd(8'h38, 2, 1'b1);
    print_verdict();
  end
endmodule // see_top_test
